// >>> scg_pkg.sv
// constants of the serial-interface and general-pin control register bank
// assumes a byte-wide serial register port with 7-bit register addresses
package scg_pkg;
    localparam int          ADDR_W            = 7;
    localparam int          NUM_PINS          = 7;
    // ******************************************************
    // register offsets
    // ******************************************************
    localparam logic [6:0]  READOUT_START_ADDR = 7'h09;
    localparam logic [6:0]  READOUT_SIZE_ADDR  = 7'h0a;
    localparam logic [6:0]  PIN_DIR_ADDR       = 7'h0e;
    localparam logic [6:0]  READY_PIN_ADDR     = 7'h11;
    localparam logic [6:0]  CHECK_CTRL_ADDR    = 7'h13;
    localparam logic [6:0]  CHECK_VALUE_ADDR   = 7'h1d;
    localparam logic [6:0]  CONV_LOW_ADDR      = 7'h1b;
    // ******************************************************
    // field positions
    // ******************************************************
    localparam int          READY_ON_PIN6_BIT  = 7;
    localparam int          CRC_CLR_DIS_BIT    = 5;
    localparam int          GAIN_CAL_SEL_BIT   = 3;
    localparam int          CRC_ENABLE_BIT     = 4;
    localparam int          RELEASE_AFTER_BIT  = 2;
    localparam int          PIN6_IDX           = 6;
    // ******************************************************
    // reset values, write masks and check defaults
    // ******************************************************
    localparam logic [6:0]  READOUT_START_RST  = 7'h1a;
    localparam logic [2:0]  READOUT_COUNT_RST  = 3'h2;
    localparam logic [6:0]  PIN_DIR_RST        = 7'h00;
    localparam logic [7:0]  READY_PIN_RST      = 8'h03;
    localparam logic [7:0]  READY_PIN_MASK     = 8'hab;
    localparam logic [7:0]  CHECK_CTRL_RST     = 8'h00;
    localparam logic [7:0]  CHECK_CTRL_MASK    = 8'h1c;
    localparam logic [7:0]  CRC_POLY_DEF       = 8'h07;
    localparam logic [7:0]  CRC_SEED_DEF       = 8'h00;

    typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA, PH_DONE} scg_phase_t;
endpackage : scg_pkg

// >>> scg_crc8_step.sv
// one-byte update of the 8-bit link check value, msb first
// assumes the caller registers the result
`timescale 1ns/1ns
module scg_crc8_step #(
    parameter logic [7:0] POLY = 8'h07
) (
    input  wire logic [7:0] crc_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] crc_o
);
    always_comb begin
        logic [7:0] c;
        c = crc_i ^ data_i;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ POLY) : {c[6:0], 1'b0};
        end
        crc_o = c;
    end
endmodule : scg_crc8_step

// >>> scg_ctrl_regs.sv
// serial register port, ready signal, link check value and pin control
// assumes sclk/csb/sdi/pins asynchronous; sclk well below clk_i/4
`timescale 1ns/1ns
module scg_ctrl_regs
    import scg_pkg::*;
#(
    parameter logic [7:0] CRC_POLY = CRC_POLY_DEF,
    parameter logic [7:0] CRC_SEED = CRC_SEED_DEF
) (
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                sclk_i,
    input  wire logic                csb_n_i,
    input  wire logic                sdi_i,
    output logic                     sdo_o,
    output logic                     sdo_oe_o,
    input  wire logic                data_only_i,
    input  wire logic                conv_done_i,
    output logic [ADDR_W-1:0]        ext_rd_addr_o,
    input  wire logic [7:0]          ext_rd_data_i,
    output logic                     ext_wr_o,
    output logic [ADDR_W-1:0]        ext_wr_addr_o,
    output logic [7:0]               ext_wr_data_o,
    input  wire logic [NUM_PINS-1:0] gpio_out_i,
    output logic [NUM_PINS-1:0]      gpio_in_o,
    input  wire logic [NUM_PINS-1:0] gpio_i,
    output logic [NUM_PINS-1:0]      gpio_o,
    output logic [NUM_PINS-1:0]      gpio_oe_o,
    output logic                     data_ready_n_o,
    output logic                     gain_cal_last_coef_o
);
    if (CRC_POLY[0] != 1'b1) begin : g_chk
        $error("check polynomial must have its low term set");
    end

    // ******************************************************
    // synchronisers
    // ******************************************************
    logic [2:0]          sclk_s;
    logic [2:0]          csb_s;
    logic [1:0]          sdi_s;
    logic [NUM_PINS-1:0] pin_s0;
    logic [NUM_PINS-1:0] pin_s1;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_s <= 3'h0;
            csb_s  <= 3'h7;
            sdi_s  <= 2'h0;
            pin_s0 <= '0;
            pin_s1 <= '0;
        end else begin
            sclk_s <= {sclk_s[1:0], sclk_i};
            csb_s  <= {csb_s[1:0], csb_n_i};
            sdi_s  <= {sdi_s[0], sdi_i};
            pin_s0 <= gpio_i;
            pin_s1 <= pin_s0;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    assign sclk_rise   = sclk_s[1] & ~sclk_s[2];
    assign sclk_fall   = ~sclk_s[1] & sclk_s[2];
    assign frame_start = csb_s[2] & ~csb_s[1];

    // ******************************************************
    // registers
    // ******************************************************
    logic [6:0]          start_q;
    logic [2:0]          count_q;
    logic [6:0]          dir_q;
    logic [7:0]          ready_ctl_q;
    logic [7:0]          check_ctl_q;
    logic [7:0]          crc_q;
    logic                drdy_q;
    scg_phase_t          phase_q;
    logic [2:0]          bit_cnt_q;
    logic [7:0]          rx_q;
    logic [7:0]          tx_q;
    logic [6:0]          addr_q;
    logic                rw_q;
    logic                only_q;
    logic [2:0]          left_q;
    logic                load_q;
    logic [7:0]          rd_data;
    logic [7:0]          rx_byte;
    logic [7:0]          crc_next;
    logic                byte_done;
    logic                wr_en;
    logic                rd_done;
    logic                release_ev;
    logic                crc_clr;

    logic ready_sel;
    logic crc_en;
    logic after_crc;
    assign ready_sel = ready_ctl_q[READY_ON_PIN6_BIT];
    assign crc_en    = check_ctl_q[CRC_ENABLE_BIT];
    assign after_crc = check_ctl_q[RELEASE_AFTER_BIT];

    assign rx_byte   = {rx_q[6:0], sdi_s[1]};
    assign byte_done = sclk_rise && (bit_cnt_q == 3'h7) && (phase_q inside {PH_CMD, PH_DATA});
    assign wr_en     = byte_done && (phase_q == PH_DATA) && !rw_q;
    assign rd_done   = byte_done && (phase_q == PH_DATA) && rw_q;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_q     <= READOUT_START_RST;
            count_q     <= READOUT_COUNT_RST;
            dir_q       <= PIN_DIR_RST;
            ready_ctl_q <= READY_PIN_RST;
            check_ctl_q <= CHECK_CTRL_RST;
        end else if (wr_en) begin
            unique case (addr_q)
                READOUT_START_ADDR: start_q     <= rx_byte[6:0];
                READOUT_SIZE_ADDR:  count_q     <= rx_byte[2:0];
                PIN_DIR_ADDR:       dir_q       <= rx_byte[6:0];
                READY_PIN_ADDR:     ready_ctl_q <= rx_byte & READY_PIN_MASK;
                CHECK_CTRL_ADDR:    check_ctl_q <= rx_byte & CHECK_CTRL_MASK;
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (addr_q)
            READOUT_START_ADDR: rd_data = {1'b0, start_q};
            READOUT_SIZE_ADDR:  rd_data = {5'h00, count_q};
            PIN_DIR_ADDR:       rd_data = {1'b0, dir_q};
            READY_PIN_ADDR:     rd_data = ready_ctl_q;
            CHECK_CTRL_ADDR:    rd_data = check_ctl_q;
            CHECK_VALUE_ADDR:   rd_data = crc_q;
            default:            rd_data = ext_rd_data_i;
        endcase
    end

    assign ext_rd_addr_o = addr_q;
    assign ext_wr_o      = wr_en && !(addr_q inside {READOUT_START_ADDR, READOUT_SIZE_ADDR,
                           PIN_DIR_ADDR, READY_PIN_ADDR, CHECK_CTRL_ADDR, CHECK_VALUE_ADDR});
    assign ext_wr_addr_o = addr_q;
    assign ext_wr_data_o = rx_byte;
    assign gain_cal_last_coef_o = ready_ctl_q[GAIN_CAL_SEL_BIT];

    // ******************************************************
    // serial frame engine
    // ******************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_q   <= PH_IDLE;
            bit_cnt_q <= 3'h0;
            rx_q      <= 8'h00;
            tx_q      <= 8'h00;
            addr_q    <= 7'h00;
            rw_q      <= 1'b0;
            only_q    <= 1'b0;
            left_q    <= 3'h0;
            load_q    <= 1'b0;
        end else if (csb_s[1]) begin
            phase_q   <= PH_IDLE;
            bit_cnt_q <= 3'h0;
            load_q    <= 1'b0;
            only_q    <= 1'b0;
        end else if (frame_start) begin
            bit_cnt_q <= 3'h0;
            if (data_only_i) begin
                phase_q <= PH_DATA;
                rw_q    <= 1'b1;
                only_q  <= 1'b1;
                addr_q  <= start_q;
                left_q  <= count_q;
                load_q  <= 1'b1;
            end else begin
                phase_q <= PH_CMD;
            end
        end else begin
            load_q <= 1'b0;
            if (load_q) begin
                tx_q <= rd_data;
            end else if (sclk_fall && bit_cnt_q != 3'h0 && phase_q == PH_DATA && rw_q) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
            if (sclk_rise) begin
                rx_q      <= rx_byte;
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (byte_done && phase_q == PH_CMD) begin
                rw_q    <= rx_byte[7];
                addr_q  <= rx_byte[6:0];
                phase_q <= PH_DATA;
                load_q  <= rx_byte[7];
            end else if (byte_done) begin
                addr_q <= addr_q + 7'h01;
                if (rd_done && only_q && left_q == 3'h0) begin
                    phase_q <= PH_DONE;
                    tx_q    <= 8'h00;
                end else begin
                    left_q <= left_q - 3'h1;
                    load_q <= rw_q;
                end
            end
        end
    end

    assign sdo_o    = tx_q[7];
    assign sdo_oe_o = ~csb_s[1];

    // ******************************************************
    // data ready and link check value
    // ******************************************************
    assign release_ev = rd_done && (after_crc ? (addr_q == CHECK_VALUE_ADDR)
                                              : (addr_q == CONV_LOW_ADDR));
    assign crc_clr    = (wr_en && addr_q == CHECK_VALUE_ADDR)
                      || (release_ev && !drdy_q && !ready_ctl_q[CRC_CLR_DIS_BIT]);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            drdy_q <= 1'b1;
        end else if (conv_done_i) begin
            drdy_q <= 1'b0;
        end else if (release_ev) begin
            drdy_q <= 1'b1;
        end
    end

    logic [7:0] tx_byte_sent;
    logic [7:0] sent_q;
    assign tx_byte_sent = sent_q;

    scg_crc8_step #(.POLY(CRC_POLY)) u_crc (
        .crc_i  (crc_q),
        .data_i (tx_byte_sent),
        .crc_o  (crc_next)
    );

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sent_q <= 8'h00;
        end else if (load_q) begin
            sent_q <= rd_data;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            crc_q <= CRC_SEED;
        end else if (crc_clr) begin
            crc_q <= CRC_SEED;
        end else if (rd_done && crc_en && addr_q != CHECK_VALUE_ADDR) begin
            crc_q <= crc_next;
        end
    end

    assign data_ready_n_o = drdy_q;

    // ******************************************************
    // general pins
    // ******************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gpio_o    <= '0;
            gpio_oe_o <= '0;
            gpio_in_o <= '0;
        end else begin
            gpio_o    <= gpio_out_i;
            gpio_oe_o <= dir_q;
            gpio_in_o <= pin_s1;
            if (ready_sel) begin
                gpio_o[PIN6_IDX]    <= drdy_q;
                gpio_oe_o[PIN6_IDX] <= 1'b1;
                gpio_in_o[PIN6_IDX] <= 1'b0;
            end
        end
    end

    // ******************************************************
    // assertions
    // ******************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_release_low: assert property (rd_done && !after_crc && addr_q == CONV_LOW_ADDR
        && !conv_done_i |=> drdy_q) else $error("ready not released after low byte");
    a_hold_for_check: assert property (rd_done && after_crc && addr_q == CONV_LOW_ADDR
        && !drdy_q && !conv_done_i |=> !drdy_q) else $error("ready released early");
    a_write_clears: assert property (wr_en && addr_q == CHECK_VALUE_ADDR
        |=> crc_q == CRC_SEED) else $error("check write did not clear");
    a_release_clears: assert property ($rose(drdy_q) && !ready_ctl_q[CRC_CLR_DIS_BIT]
        |-> crc_q == CRC_SEED) else $error("release did not clear check");
    a_crc_gated: assert property (!crc_en && !crc_clr
        |=> $stable(crc_q)) else $error("check changed while disabled");
    a_crc_read: assert property (load_q && addr_q == CHECK_VALUE_ADDR && !csb_s[1]
        |=> tx_q == $past(crc_q)) else $error("check read mismatch");
    a_pin6_ready: assert property (ready_sel |=> gpio_oe_o[PIN6_IDX]
        && gpio_o[PIN6_IDX] == $past(drdy_q) && !gpio_in_o[PIN6_IDX])
        else $error("pin six not carrying ready");
    a_pin_dir: assert property (##1 gpio_oe_o[5:0] == $past(dir_q[5:0]))
        else $error("direction not applied");
    a_only_start: assert property (frame_start && !csb_s[1] && data_only_i
        |=> addr_q == $past(start_q) && left_q == $past(count_q))
        else $error("data-only start wrong");
    a_only_end: assert property (rd_done && only_q && left_q == 3'h0 && !csb_s[1]
        |=> phase_q == PH_DONE) else $error("data-only length wrong");

    c_only_done: cover property (phase_q == PH_DATA ##1 phase_q == PH_DONE);
    c_check_read: cover property (rd_done && addr_q == CHECK_VALUE_ADDR);
    c_release: cover property (!drdy_q ##1 drdy_q);
    c_check_clear: cover property (wr_en && addr_q == CHECK_VALUE_ADDR);
endmodule : scg_ctrl_regs

// >>> scg_spi_host.sv
// host model: mode 0 frames, msb first, serial clock 80 ns
// assumes clk_i at 100 MHz; caller fills tx_buf, reads rx_buf
`timescale 1ns/1ns
module scg_spi_host (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      sclk_o,
    output logic      csb_n_o,
    output logic      sdi_o
);
    logic [7:0] tx_buf [10];
    logic [7:0] rx_buf [10];
    initial begin
        sclk_o  = 1'b0;
        csb_n_o = 1'b1;
        sdi_o   = 1'b0;
    end
    task automatic run(input int n);
        @(posedge clk_i) csb_n_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                @(posedge clk_i);
                sdi_o  <= tx_buf[i][b];
                sclk_o <= 1'b0;
                repeat (4) @(posedge clk_i);
                sclk_o       <= 1'b1;
                rx_buf[i][b] =  sdo_i;
                repeat (3) @(posedge clk_i);
            end
        end
        @(posedge clk_i) sclk_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        csb_n_o <= 1'b1;
        // deselected line shows no stale bit
        sdi_o   <= ~sdi_o;
        repeat (8) @(posedge clk_i);
    endtask : run
endmodule : scg_spi_host

// >>> scg_ctrl_regs_tb.sv
// self-checking bench of the control register bank
// assumes scg_pkg, scg_ctrl_regs and scg_spi_host compiled first
`timescale 1ns/1ns
module scg_ctrl_regs_tb;
    import scg_pkg::*;
    logic       clk_i, sys_rst_i, data_only_i, conv_done_i;
    logic       sclk, csb_n, sdi, sdo, drdy_n, gcal;
    logic [6:0] rd_addr, gp_out, gp_in, gp_pin, gp_drv, gp_oe, ext_pin;
    logic [7:0] rd_data, c;
    logic       sdo_oe, ext_wr;
    logic       oe_seen = 1'b0;
    logic [6:0] ext_wr_addr;
    logic [7:0] ext_wr_data;
    logic [7:0] ext_cnt = 8'h00;
    logic [14:0] ext_last;
    int         num_errors = 0;
    int         n_compared = 0;
    // ****************************************
    // clock, neighbours, pins
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic [7:0] nbr(input logic [6:0] a);
        return {a, 1'b1} ^ 8'h5a;
    endfunction : nbr
    function automatic logic [7:0] crc8(input logic [7:0] s, d);
        logic [7:0] r;
        r = s ^ d;
        for (int k = 0; k < 8; k++)
            r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
        return r;
    endfunction : crc8
    assign rd_data = nbr(rd_addr);
    assign gp_pin  = (gp_oe & gp_drv) | (~gp_oe & ext_pin);
    // records output enable and neighbour write pulses
    always @(posedge clk_i) begin
        if (sdo_oe)
            oe_seen <= 1'b1;
        if (ext_wr) begin
            ext_cnt  <= ext_cnt + 8'h01;
            ext_last <= {ext_wr_addr, ext_wr_data};
        end
    end
    scg_spi_host host (.clk_i(clk_i), .sdo_i(sdo), .sclk_o(sclk), .csb_n_o(csb_n),
        .sdi_o(sdi));
    scg_ctrl_regs uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
        .csb_n_i(csb_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .data_only_i(data_only_i), .conv_done_i(conv_done_i), .ext_rd_addr_o(rd_addr),
        .ext_rd_data_i(rd_data), .ext_wr_o(ext_wr), .ext_wr_addr_o(ext_wr_addr),
        .ext_wr_data_o(ext_wr_data), .gpio_out_i(gp_out),
        .gpio_in_o(gp_in), .gpio_i(gp_pin), .gpio_o(gp_drv), .gpio_oe_o(gp_oe),
        .data_ready_n_o(drdy_n), .gain_cal_last_coef_o(gcal));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_clk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.tx_buf[0] = {1'b0, a};
        host.tx_buf[1] = d;
        host.run(2);
        wait_clk(1);
    endtask : wr
    task automatic rd(input logic [6:0] a, input int n);
        host.tx_buf[0] = {1'b1, a};
        for (int i = 1; i < 10; i++) host.tx_buf[i] = 8'h00;
        host.run(n + 1);
        wait_clk(1);
    endtask : rd
    task automatic pulse_conv();
        @(posedge clk_i) conv_done_i <= 1'b1;
        @(posedge clk_i) conv_done_i <= 1'b0;
        wait_clk(2);
    endtask : pulse_conv
    task automatic give_verdict();
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd(READOUT_SIZE_ADDR, 1);
        chk(host.rx_buf[1], 8'h02);
        chk({7'h0, sdo_oe}, 8'h00);
        chk({7'h0, oe_seen}, 8'h01);
        rd(READOUT_START_ADDR, 1);
        chk(host.rx_buf[1], 8'h1a);
        rd(READY_PIN_ADDR, 1);
        chk(host.rx_buf[1], 8'h03);
        rd(PIN_DIR_ADDR, 1);
        chk(host.rx_buf[1], 8'h00);
        chk({1'b0, gp_oe}, 8'h00);
        rd(CHECK_CTRL_ADDR, 1);
        chk(host.rx_buf[1], 8'h00);
        chk({7'h0, drdy_n}, 8'h01);
    endtask : t_reset
    task automatic t_pins();
        wr(7'h0f, 8'h2a);
        chk(ext_cnt, 8'h01);
        chk({1'b0, ext_last[14:8]}, 8'h0f);
        chk(ext_last[7:0], 8'h2a);
        wr(PIN_DIR_ADDR, 8'h15);
        wait_clk(4);
        chk({1'b0, gp_oe}, 8'h15);
        chk({1'b0, gp_drv & 7'h15}, {1'b0, gp_out & 7'h15});
        chk({1'b0, gp_in & 7'h6a}, {1'b0, ext_pin & 7'h6a});
        wr(READY_PIN_ADDR, 8'h8b);
        wait_clk(4);
        chk({7'h0, gcal}, 8'h01);
        chk({6'h0, gp_oe[6], gp_drv[6]}, 8'h03);
        chk({7'h0, gp_in[6]}, 8'h00);
        pulse_conv();
        chk({7'h0, gp_drv[6]}, 8'h00);
        wr(READY_PIN_ADDR, 8'h03);
        wait_clk(4);
        chk({7'h0, gcal}, 8'h00);
        chk({6'h0, gp_oe[6], gp_in[6]}, 8'h01);
    endtask : t_pins
    task automatic t_crc_after();
        wr(READY_PIN_ADDR, 8'h23);
        wr(CHECK_CTRL_ADDR, 8'h14);
        wr(CHECK_VALUE_ADDR, 8'hff);
        pulse_conv();
        rd(7'h1a, 3);
        c = 8'h00;
        for (int i = 0; i < 3; i++) begin
            chk(host.rx_buf[i + 1], nbr(7'h1a + 7'(i)));
            c = crc8(c, nbr(7'h1a + 7'(i)));
        end
        chk({7'h0, drdy_n}, 8'h00);
        rd(CHECK_VALUE_ADDR, 1);
        chk(host.rx_buf[1], c);
        chk({7'h0, drdy_n}, 8'h01);
        rd(CHECK_VALUE_ADDR, 1);
        chk(host.rx_buf[1], c);
        wr(CHECK_VALUE_ADDR, 8'h5c);
        chk(ext_cnt, 8'h01);
        rd(CHECK_VALUE_ADDR, 1);
        chk(host.rx_buf[1], 8'h00);
    endtask : t_crc_after
    task automatic t_crc_clear();
        wr(READY_PIN_ADDR, 8'h03);
        wr(CHECK_CTRL_ADDR, 8'h10);
        pulse_conv();
        rd(7'h1a, 1);
        chk({7'h0, drdy_n}, 8'h00);
        rd(CONV_LOW_ADDR, 1);
        chk({7'h0, drdy_n}, 8'h01);
        rd(CHECK_VALUE_ADDR, 1);
        chk(host.rx_buf[1], 8'h00);
        wr(CHECK_CTRL_ADDR, 8'h00);
        rd(7'h1c, 1);
        rd(CHECK_VALUE_ADDR, 1);
        chk(host.rx_buf[1], 8'h00);
    endtask : t_crc_clear
    task automatic t_data_only(input logic [2:0] cnt, input logic [6:0] sa);
        if (sa != 7'h1a)
            wr(READOUT_START_ADDR, {1'b0, sa});
        if (cnt != 3'h2)
            wr(READOUT_SIZE_ADDR, {5'h0, cnt});
        for (int i = 0; i < 10; i++) host.tx_buf[i] = 8'h00;
        @(posedge clk_i) data_only_i <= 1'b1;
        host.run(int'(cnt) + 2);
        @(posedge clk_i) data_only_i <= 1'b0;
        for (int i = 0; i <= int'(cnt); i++) begin
            c = (sa + 7'(i) == CHECK_VALUE_ADDR) ? 8'h00 : nbr(sa + 7'(i));
            chk(host.rx_buf[i], c);
        end
        chk(host.rx_buf[int'(cnt) + 1], 8'h00);
    endtask : t_data_only
    initial begin
        sys_rst_i   = 1'b1;
        data_only_i = 1'b0;
        conv_done_i = 1'b0;
        gp_out      = 7'h33;
        ext_pin     = 7'h6a;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_reset();
        t_pins();
        t_crc_after();
        t_crc_clear();
        t_data_only(3'h2, 7'h1a);
        t_data_only(3'h0, 7'h1a);
        t_data_only(3'h7, 7'h1b);
        give_verdict();
    end
    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end
endmodule : scg_ctrl_regs_tb
